// >>> rtl/amp_sup_map.svh
//============================================================================
// Purpose: Constants for the amplifier state and fault supervisor
// Assumes: Included by its bare name; definitions only
// Notes:   SY bit positions index the synchroniser vector, GL ones the latched faults
// Function
// - Open-drain alarm low on protective Hi-Z/standby
// - Supply excursion forces standby, stops bus, alarms
// - Warning pin selects thermal, clip or both
// - Tweeter found asserts warning pin during diagnostics
// - Soft-silence pin low mutes all channels by ramp
// - Deep-sleep pin clears state, faults and settings, bus goes idle
// - Channel phase step selectable 45 or 180 degrees
// - Standby, Hi-Z, mute, normal output behaviours
// - Overcurrent and dc-detect latch channel into Hi-Z
// - Cycle limit flags warning pin, starts timer
// - Down ramp 2/3 to 1/3, mute status at 1/10
// - Up ramp from 1/3, play status at 9/10
// - Ramp starts when mode command is taken
// - Warning select 00 tweeter, 01 clip, 10 thermal
// - Frequency code 00/01/10 valid, 11 ignored
//============================================================================
`ifndef AMP_SUP_MAP_SVH
`define AMP_SUP_MAP_SVH

// Switching frequency select codes
`define FS_500      2'h0
`define FS_417      2'h1
`define FS_357      2'h2
`define FS_BAD      2'h3
`define FS_RST      2'h1

// Warning pin function codes
`define WS_TWEET    2'h0
`define WS_CLIP     2'h1
`define WS_THERM    2'h2
`define WS_BOTH     2'h3
`define WS_RST      2'h3

// Phase steps in units of 45 degrees
`define PH_45       3'h1
`define PH_180      3'h4

// Threshold comparator bit positions on the soft-silence pin
`define TH_TENTH    0
`define TH_THIRD    1
`define TH_TWO3RD   2
`define TH_NINE10   3

// Synchroniser vector layout
`define SY_SLEEP    0
`define SY_MUTE     1
`define SY_THR      2
`define SY_POR      6
`define SY_LDUMP    7
`define SY_GLAT     8
`define SY_TWARN    12
`define SY_CLIP     13
`define SY_CBC      17
`define SY_OC       21
`define SY_DC       25
`define SY_TWEET    29
`define SY_W        33
`define SY_RST      33'h000000003

// Latched global fault bit positions
`define GL_UV       0
`define GL_PUV      1
`define GL_OV       2
`define GL_TSD      3

`endif

// >>> rtl/amp_sup_pkg.sv
//============================================================================
// Purpose: Types shared by the supervisor modules
// Assumes: Nothing
// Notes:   Constants live in the map header
//============================================================================
package amp_sup_pkg;
   typedef enum logic [1:0] {G_STANDBY, G_HIZ, G_ACTIVE} gstate_t;
   typedef enum logic [1:0] {CH_HIZ, CH_MUTE, CH_PLAY} ch_state_t;
   typedef enum logic [1:0] {GAIN_OFF, GAIN_RAMP, GAIN_FULL} gain_t;
endpackage : amp_sup_pkg

// >>> rtl/ramp_if.sv
//============================================================================
// Purpose: Carrier between supervisor and gain ramp tracker
// Assumes: Same clock on both ends
// Notes:   Threshold bits are already synchronised
//============================================================================
interface ramp_if;
   import amp_sup_pkg::*;
   logic        dir_up;
   logic [3:0]  thr;
   gain_t       gain;
   logic        mute_st;
   logic        play_st;
   modport tracker (input dir_up, input thr,
                    output gain, output mute_st, output play_st);
   modport ctrl    (output dir_up, output thr,
                    input gain, input mute_st, input play_st);
endinterface : ramp_if

// >>> rtl/gain_ramp_tracker.sv
//============================================================================
// Purpose: Follows the soft-silence pin against reference fractions
// Assumes: Comparator bits synchronised; rst asynchronous active high
// Notes:   Status bits lag the gain so software sees settled modes
//============================================================================
`include "amp_sup_map.svh"
module gain_ramp_tracker
   import amp_sup_pkg::*;
(
   // Clock and reset
   input wire logic  clk,
   input wire logic  rst,
   input wire logic  clr,
   // Ramp carrier
   ramp_if.tracker   rp
);
   gain_t gain_r, gain_nxt;
   logic  mute_r, mute_nxt;
   logic  play_r, play_nxt;

   //=========================================================================
   // Gain and status next values
   always_comb begin
      // Gain moves only between the one-third and two-thirds points
      if (rp.thr[`TH_TWO3RD]) begin
         gain_nxt = GAIN_FULL;
      end else if (rp.thr[`TH_THIRD]) begin
         gain_nxt = GAIN_RAMP;
      end else begin
         gain_nxt = GAIN_OFF;
      end
      mute_nxt = mute_r;
      play_nxt = play_r;
      if (!rp.dir_up && !rp.thr[`TH_TENTH]) begin
         mute_nxt = 1'b1;
         play_nxt = 1'b0;
      end else if (rp.dir_up && rp.thr[`TH_NINE10]) begin
         mute_nxt = 1'b0;
         play_nxt = 1'b1;
      end
      if (clr) begin
         gain_nxt = GAIN_OFF;
         mute_nxt = 1'b1;
         play_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gain_r <= GAIN_OFF;
         mute_r <= 1'b1;
         play_r <= 1'b0;
      end else begin
         gain_r <= gain_nxt;
         mute_r <= mute_nxt;
         play_r <= play_nxt;
      end
   end

   assign rp.gain    = gain_r;
   assign rp.mute_st = mute_r;
   assign rp.play_st = play_r;

   //=========================================================================
   // Checks
   sequence s_down_low;
      !rp.dir_up && !rp.thr[`TH_TENTH] && !clr;
   endsequence
   sequence s_up_high;
      rp.dir_up && rp.thr[`TH_NINE10] && !clr;
   endsequence
   a_mute_at_tenth: assert property (@(posedge clk) disable iff (rst)
      s_down_low |=> mute_r && !play_r)
      else $error("mute status not set below one tenth");
   a_play_at_ninth: assert property (@(posedge clk) disable iff (rst)
      s_up_high |=> play_r && !mute_r)
      else $error("play status not set above nine tenths");
   a_status_early: assert property (@(posedge clk) disable iff (rst)
      (!rp.dir_up && rp.thr[`TH_TENTH] && !clr && !mute_r)
      |=> !mute_r)
      else $error("mute status set before one tenth");
   a_gain_window: assert property (@(posedge clk) disable iff (rst)
      (rp.thr[`TH_THIRD] && !rp.thr[`TH_TWO3RD] && !clr)
      |=> gain_r == GAIN_RAMP)
      else $error("gain not ramping inside window");
endmodule : gain_ramp_tracker

// >>> rtl/amp_state_fault_supervisor.sv
//============================================================================
// Purpose: Operating state and fault supervisor of a 4-channel amplifier
// Assumes: One 250 MHz clock; rst asynchronous active high
// Notes:   Pins and monitors are analog, so all pass a 3-stage synchroniser
//============================================================================
`include "amp_sup_map.svh"
module amp_state_fault_supervisor
   import amp_sup_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Control pins and pin threshold comparators
   input  wire logic              deep_sleep_n,
   input  wire logic              mute_pin_n,
   input  wire logic [3:0]        thr_cmp,
   // Global monitors
   input  wire logic              power_on_reset,
   input  wire logic              load_dump,
   input  wire logic              undervoltage,
   input  wire logic              pump_undervoltage,
   input  wire logic              overvoltage,
   input  wire logic              thermal_warning,
   input  wire logic              thermal_shutdown,
   // Channel monitors
   input  wire logic [3:0]        clip_detect,
   input  wire logic [3:0]        cycle_current_limit,
   input  wire logic [3:0]        overcurrent_fault,
   input  wire logic [3:0]        dc_detect,
   input  wire logic [3:0]        tweeter_found,
   // Host mode commands
   input  wire logic              cmd_valid,
   input  wire logic [3:0]        cmd_hiz,
   input  wire logic              cmd_play,
   input  wire logic              fault_clear,
   // Host configuration
   input  wire logic              cfg_valid,
   input  wire logic [1:0]        cfg_fs_sel,
   input  wire logic [1:0]        cfg_warn_sel,
   input  wire logic              cfg_phase_180,
   input  wire logic              cfg_tweeter_mode,
   input  wire logic              cfg_dc_detect_en,
   // Pins out
   output logic                   fault_alarm_o,
   output logic                   fault_alarm_oe_n,
   output logic                   clip_thermal_warn_n,
   output logic                   ramp_charge,
   // State and status
   output logic                   standby,
   output logic                   i2c_enable,
   output ch_state_t [3:0]        ch_state,
   output gain_t                  gain_level,
   output logic                   mute_status,
   output logic                   play_status,
   output logic [3:0]             global_fault,
   output logic                   warn_status,
   output logic [3:0]             ch_oc_fault,
   output logic [3:0]             ch_dc_fault,
   output logic [3:0]             oc_timer_start,
   // Switching setup
   output logic [3:0][2:0]        ch_phase,
   output logic [1:0]             fs_sel
);
   //=========================================================================
   // Three-stage synchronisers; a change counts once stages 2 and 3 agree
   logic [`SY_W-1:0] raw, ff1_r, ff2_r, ff3_r, s_r;
   assign raw = {tweeter_found, dc_detect, overcurrent_fault,
                 cycle_current_limit, clip_detect, thermal_warning,
                 thermal_shutdown, overvoltage, pump_undervoltage,
                 undervoltage, load_dump, power_on_reset, thr_cmp,
                 mute_pin_n, deep_sleep_n};
   localparam logic [`SY_W-1:0] sync_init = `SY_RST;   // Idle pin levels
   genvar gi;
   generate
      for (gi = 0; gi < `SY_W; gi++) begin : g_sync
         logic s_nxt;
         assign s_nxt = (ff2_r[gi] == ff3_r[gi]) ? ff3_r[gi] : s_r[gi];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               ff1_r[gi] <= sync_init[gi];
               ff2_r[gi] <= sync_init[gi];
               ff3_r[gi] <= sync_init[gi];
               s_r[gi]   <= sync_init[gi];
            end else begin
               ff1_r[gi] <= raw[gi];
               ff2_r[gi] <= ff1_r[gi];
               ff3_r[gi] <= ff2_r[gi];
               s_r[gi]   <= s_nxt;
            end
         end
      end
   endgenerate

   logic       sleep, supply_stop;
   logic [3:0] oc_s, dc_s, cbc_s, clip_s, tw_s;
   assign sleep       = !s_r[`SY_SLEEP];
   assign supply_stop = s_r[`SY_POR] | s_r[`SY_LDUMP];
   assign oc_s  = s_r[`SY_OC +: 4];
   assign dc_s  = s_r[`SY_DC +: 4];
   assign cbc_s = s_r[`SY_CBC +: 4];
   assign clip_s = s_r[`SY_CLIP +: 4];
   assign tw_s  = s_r[`SY_TWEET +: 4];

   //=========================================================================
   // Gain ramp tracker
   ramp_if rp ();
   gain_ramp_tracker u_ramp (
      .clk (clk),
      .rst (rst),
      .clr (sleep),
      .rp  (rp.tracker)
   );
   assign rp.thr = s_r[`SY_THR +: 4];
   assign rp.dir_up = ramp_charge;
   assign gain_level  = rp.gain;
   assign mute_status = rp.mute_st;
   assign play_status = rp.play_st;

   //=========================================================================
   // Supervisor state
   gstate_t          gst_r, gst_nxt;
   ch_state_t [3:0]  ch_nxt;
   logic [3:0]       glat_nxt, oc_nxt, dc_nxt, hiz_r, hiz_nxt, cbc_d_r;
   logic [3:0]       cbc_nxt, tstart_nxt;
   logic [3:0][2:0]  ph_nxt;
   logic [1:0]       fs_nxt, ws_r, ws_nxt;
   logic             play_r, play_nxt, twm_r, twm_nxt, dce_r, dce_nxt;
   logic             ph180_r, ph180_nxt, ramp_nxt, alarm_nxt, warn_nxt;
   logic             clr, mon_on, wsel;

   always_comb begin
      // A command or an explicit clear releases latched faults
      clr      = fault_clear | cmd_valid;
      mon_on   = gst_r != G_STANDBY;
      hiz_nxt  = cmd_valid ? cmd_hiz : hiz_r;
      play_nxt = cmd_valid ? cmd_play : play_r;
      fs_nxt   = fs_sel;
      ws_nxt   = ws_r;
      twm_nxt  = twm_r;
      dce_nxt  = dce_r;
      ph180_nxt = ph180_r;
      if (cfg_valid) begin
         if (cfg_fs_sel != `FS_BAD) begin
            fs_nxt = cfg_fs_sel;
         end
         ws_nxt    = cfg_warn_sel;
         twm_nxt   = cfg_tweeter_mode;
         dce_nxt   = cfg_dc_detect_en;
         ph180_nxt = cfg_phase_180;
      end
      // Set beats clear so an event in the clear cycle survives
      glat_nxt = (global_fault & ~{4{clr}})
               | (s_r[`SY_GLAT +: 4] & {4{mon_on}});
      for (int i = 0; i < 4; i++) begin
         oc_nxt[i] = (ch_oc_fault[i] & !clr)
                   | (oc_s[i] & (ch_state[i] != CH_HIZ));
         dc_nxt[i] = (ch_dc_fault[i] & !clr)
                   | (dc_s[i] & dce_r & (ch_state[i] == CH_PLAY));
         ph_nxt[i] = 3'(i * (ph180_r ? `PH_180 : `PH_45));
      end
      // Supply excursions and thermal shutdown park in standby
      if (supply_stop || global_fault[`GL_TSD]) begin
         gst_nxt = G_STANDBY;
      end else if (|global_fault[`GL_OV:`GL_UV]) begin
         gst_nxt = G_HIZ;
      end else begin
         gst_nxt = G_ACTIVE;
      end
      // Pin low pulls the ramp down for all channels at once
      ramp_nxt = play_nxt & s_r[`SY_MUTE]
               & (gst_r == G_ACTIVE);
      for (int i = 0; i < 4; i++) begin
         if (gst_r != G_ACTIVE || hiz_r[i] || ch_oc_fault[i]
             || ch_dc_fault[i]) begin
            ch_nxt[i] = CH_HIZ;
         end else if (rp.gain == GAIN_OFF) begin
            ch_nxt[i] = CH_MUTE;
         end else begin
            ch_nxt[i] = CH_PLAY;
         end
      end
      alarm_nxt = supply_stop | (|global_fault) | (|ch_oc_fault)
                | (|ch_dc_fault);
      unique case (ws_r)
         `WS_TWEET: wsel = 1'b0;
         `WS_CLIP:  wsel = |clip_s;
         `WS_THERM: wsel = s_r[`SY_TWARN];
         `WS_BOTH:  wsel = (|clip_s) | s_r[`SY_TWARN];
      endcase
      cbc_nxt    = cbc_s;
      tstart_nxt = cbc_s & ~cbc_d_r;
      warn_nxt = wsel | (|cbc_s) | (twm_r & (|tw_s));
      // Deep sleep drops every setting back to its reset value
      if (sleep) begin
         gst_nxt = G_STANDBY;
         glat_nxt = 4'h0;
         oc_nxt = 4'h0;
         dc_nxt = 4'h0;
         hiz_nxt = 4'hf;
         play_nxt = 1'b0;
         ramp_nxt = 1'b0;
         fs_nxt = `FS_RST;
         ws_nxt = `WS_RST;
         twm_nxt = 1'b0;
         dce_nxt = 1'b0;
         ph180_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gst_r <= G_STANDBY;
         ch_state <= '{default: CH_HIZ};
         global_fault <= 4'h0;
         ch_oc_fault <= 4'h0;
         ch_dc_fault <= 4'h0;
         hiz_r <= 4'hf;
         play_r <= 1'b0;
         fs_sel <= `FS_RST;
         ws_r <= `WS_RST;
         twm_r <= 1'b0;
         dce_r <= 1'b0;
         ph180_r <= 1'b0;
         ch_phase <= '0;
         ramp_charge <= 1'b0;
         fault_alarm_o <= 1'b0;
         fault_alarm_oe_n <= 1'b1;
         clip_thermal_warn_n <= 1'b1;
         standby <= 1'b1;
         i2c_enable <= 1'b0;
         warn_status <= 1'b0;
         cbc_d_r <= 4'h0;
         oc_timer_start <= 4'h0;
      end else begin
         gst_r <= gst_nxt;
         ch_state <= ch_nxt;
         global_fault <= glat_nxt;
         ch_oc_fault <= oc_nxt;
         ch_dc_fault <= dc_nxt;
         hiz_r <= hiz_nxt;
         play_r <= play_nxt;
         fs_sel <= fs_nxt;
         ws_r <= ws_nxt;
         twm_r <= twm_nxt;
         dce_r <= dce_nxt;
         ph180_r <= ph180_nxt;
         ch_phase <= ph_nxt;
         ramp_charge <= ramp_nxt;
         fault_alarm_o <= 1'b0;
         fault_alarm_oe_n <= !alarm_nxt;
         clip_thermal_warn_n <= !warn_nxt;
         standby <= gst_nxt == G_STANDBY;
         i2c_enable <= !(sleep | supply_stop);
         warn_status <= s_r[`SY_TWARN];
         cbc_d_r <= cbc_nxt;
         oc_timer_start <= tstart_nxt;
      end
   end

   //=========================================================================
   // Checks
   sequence s_clear_and_set;
      clr && !sleep && mon_on && (|s_r[`SY_GLAT +: 4]);
   endsequence
   a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
      s_clear_and_set |=> (global_fault & $past(s_r[`SY_GLAT +: 4]))
                          == $past(s_r[`SY_GLAT +: 4]))
      else $error("latched fault lost in clear cycle");
   a_supply_alarm: assert property (@(posedge clk) disable iff (rst)
      supply_stop |=> !fault_alarm_oe_n && !i2c_enable && standby)
      else $error("supply excursion not handled");
   a_sleep_clears: assert property (@(posedge clk) disable iff (rst)
      sleep |=> !i2c_enable && global_fault == 4'h0 && fs_sel == `FS_RST)
      else $error("deep sleep left state behind");
   a_fs_bad_kept: assert property (@(posedge clk) disable iff (rst)
      (cfg_valid && cfg_fs_sel == `FS_BAD && !sleep)
      |=> fs_sel == $past(fs_sel))
      else $error("invalid frequency code taken");
   a_phase_step: assert property (@(posedge clk) disable iff (rst)
      ph180_r |=> ch_phase[1] == `PH_180 && ch_phase[2] == 3'h0)
      else $error("180 degree phase step wrong");
   for (genvar ci = 0; ci < 4; ci++) begin : g_oc_chk
      a_oc_to_hiz: assert property (@(posedge clk) disable iff (rst)
         (oc_s[ci] && ch_state[ci] == CH_PLAY && !sleep)
         |=> ch_oc_fault[ci] ##1 ch_state[ci] == CH_HIZ)
         else $error("overcurrent did not force Hi-Z");
   end
   a_ramp_at_cmd: assert property (@(posedge clk) disable iff (rst)
      (cmd_valid && !cmd_play) |=> !ramp_charge)
      else $error("ramp not started with command");
   a_warn_therm: assert property (@(posedge clk) disable iff (rst)
      (ws_r == `WS_THERM && s_r[`SY_TWARN])
      |=> !clip_thermal_warn_n)
      else $error("thermal warning not on pin");
   a_cbc_warn: assert property (@(posedge clk) disable iff (rst)
      (|cbc_s) |=> !clip_thermal_warn_n)
      else $error("current limit not on pin");
endmodule : amp_state_fault_supervisor

// >>> bench/pin_ramp_model.sv
//========================================
// Purpose: Soft-silence pin and its comparators
// Assumes: Pin level moves 2 percent a clock
// Notes:   An outside switch on the pin drops it at once
//========================================
module pin_ramp_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pin drive
   input  wire logic       ramp_charge,
   input  wire logic       mute_pin_n,
   // Comparators
   output logic [3:0]      thr_cmp
);
   timeunit 1ns;
   timeprecision 100ps;
   int lvl;
   // Capacitor follows the drive; slow so ramp phases are visible
   always @(posedge clk or posedge rst) begin
      if (rst)
         lvl <= 0;
      else if (!mute_pin_n)
         lvl <= 0;
      else if (ramp_charge && lvl < 100)
         lvl <= lvl + 2;
      else if (!ramp_charge && lvl > 0)
         lvl <= lvl - 2;
   end
   // Fractions of the reference
   assign thr_cmp = {lvl > 90, lvl > 66, lvl > 33, lvl > 10};
endmodule : pin_ramp_model

// >>> bench/tb.sv
//========================================
// Purpose: Self-checking bench for the amplifier supervisor
// Assumes: Pin ramp model drives the comparators
// Notes:   Inputs move and outputs are read on the falling edge
//========================================
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   fails++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define WT(c) begin for (int w = 0; w < 600 && !(c); w++) \
   @(negedge clk); if (!(c)) begin fails++; \
   $display("unexpected wait exp 1 got 0"); end end
`define W(n) repeat (n) @(negedge clk)
module tb
   import amp_sup_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, deep_sleep_n, mute_pin_n, power_on_reset, load_dump;
   logic undervoltage, pump_undervoltage, overvoltage, thermal_warning;
   logic thermal_shutdown, cmd_valid, cmd_play, fault_clear, cfg_valid;
   logic cfg_phase_180, cfg_tweeter_mode, cfg_dc_detect_en, ramp_charge;
   logic [3:0] thr_cmp, clip_detect, cycle_current_limit, dc_detect;
   logic [3:0] overcurrent_fault, tweeter_found, cmd_hiz, global_fault;
   logic [3:0] ch_oc_fault, ch_dc_fault, oc_timer_start;
   logic [1:0] cfg_fs_sel, cfg_warn_sel, fs_sel;
   logic fault_alarm_o, fault_alarm_oe_n, clip_thermal_warn_n, standby;
   logic i2c_enable, mute_status, play_status, warn_status, exp_w;
   ch_state_t [3:0] ch_state;
   gain_t gain_level;
   logic [3:0][2:0] ch_phase;
   int fails, n_compared, exp_fs, c, k;
   int fsq[$] = '{0, 2, 3, 1};

   amp_state_fault_supervisor uut (.clk, .rst, .deep_sleep_n,
      .mute_pin_n, .thr_cmp, .power_on_reset, .load_dump, .undervoltage,
      .pump_undervoltage, .overvoltage, .thermal_warning,
      .thermal_shutdown, .clip_detect, .cycle_current_limit,
      .overcurrent_fault, .dc_detect, .tweeter_found, .cmd_valid,
      .cmd_hiz, .cmd_play, .fault_clear, .cfg_valid, .cfg_fs_sel,
      .cfg_warn_sel, .cfg_phase_180, .cfg_tweeter_mode, .cfg_dc_detect_en,
      .fault_alarm_o, .fault_alarm_oe_n, .clip_thermal_warn_n,
      .ramp_charge, .standby, .i2c_enable, .ch_state, .gain_level,
      .mute_status, .play_status, .global_fault, .warn_status,
      .ch_oc_fault, .ch_dc_fault, .oc_timer_start, .ch_phase, .fs_sel);
   pin_ramp_model pin (.clk, .rst, .ramp_charge, .mute_pin_n, .thr_cmp);

   // 250 MHz clock
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end

   // One-cycle configuration write; a bad frequency code is not kept
   task automatic cfg(input logic [1:0] fs, ws, input logic ph, tw);
      @(negedge clk);
      {cfg_fs_sel, cfg_warn_sel, cfg_phase_180, cfg_tweeter_mode} =
         {fs, ws, ph, tw};
      cfg_valid = 1;
      @(negedge clk);
      cfg_valid = 0;
      if (fs != 2'h3) exp_fs = fs;
   endtask : cfg

   // One-cycle mode command
   task automatic cmd(input logic [3:0] hz, input logic pl);
      @(negedge clk);
      {cmd_hiz, cmd_play, cmd_valid} = {hz, pl, 1'b1};
      @(negedge clk);
      cmd_valid = 0;
   endtask : cmd

   // Expected warning pin for select and source
   function automatic logic exp_warn(int ws, int s);
      return (s == 0) ? (ws == 1 || ws == 3) :
             (s == 1) ? (ws == 2 || ws == 3) : (ws == 0);
   endfunction : exp_warn

   task automatic give_verdict;
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // Watchdog, well beyond the few hundred cycles needed
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      give_verdict();
   end

   initial begin
      void'($urandom(32'hcb632efa));
      {rst, deep_sleep_n, mute_pin_n, power_on_reset, load_dump} = 5'h1c;
      {undervoltage, pump_undervoltage, overvoltage, thermal_warning} = 0;
      {thermal_shutdown, cmd_valid, cmd_play, fault_clear, cfg_valid} = 0;
      {cfg_phase_180, cfg_tweeter_mode, cfg_dc_detect_en, cmd_hiz} = 0;
      {clip_detect, cycle_current_limit, dc_detect, overcurrent_fault} = 0;
      {tweeter_found, cfg_fs_sel, cfg_warn_sel} = 0;
      exp_fs = 1;
      `W(4);
      `CHK("standby", 1'b1, standby)
      `CHK("oe_n", 1'b1, fault_alarm_oe_n)
      `CHK("fs_sel", 2'h1, fs_sel)
      rst = 0;
      `WT(!standby);
      `CHK("i2c", 1'b1, i2c_enable)
      // Every frequency code with a random phase step
      foreach (fsq[i]) begin
         k = $urandom_range(1);
         cfg(2'(fsq[i]), 2'h3, k[0], 1'b0);
         `W(1);
         `CHK("fs_sel", exp_fs[1:0], fs_sel)
         for (int j = 0; j < 4; j++)
            `CHK("phase", 3'(j * (k ? 4 : 1)), ch_phase[j])
      end
      // Mute, then play with the gain ramp on the pin
      cmd(4'h0, 1'b0);
      `WT(ch_state[3] === CH_MUTE);
      for (int j = 0; j < 4; j++)
         `CHK("ch_state", CH_MUTE, ch_state[j])
      cmd(4'h0, 1'b1);
      `CHK("charge", 1'b1, ramp_charge)
      `WT(gain_level === GAIN_RAMP);
      `CHK("play_st", 1'b0, play_status)
      `WT(play_status === 1'b1);
      `CHK("mute_st", 1'b0, mute_status)
      `CHK("gain", GAIN_FULL, gain_level)
      // Warning pin for each select and each source
      for (int ws = 0; ws < 4; ws++)
         for (int s = 0; s < 3; s++) begin
            cfg(exp_fs[1:0], 2'(ws), 1'b0, ws == 0);
            c = $urandom_range(3);
            clip_detect = (s == 0) ? 4'(1 << c) : 4'h0;
            thermal_warning = (s == 1);
            tweeter_found = (s == 2) ? 4'(1 << c) : 4'h0;
            `W(8);
            exp_w = !exp_warn(ws, s);
            `CHK("warn_n", exp_w, clip_thermal_warn_n)
            `CHK("warn_st", s == 1, warn_status)
            {clip_detect, thermal_warning, tweeter_found} = 0;
            `W(8);
            `CHK("warn_n", 1'b1, clip_thermal_warn_n)
            `CHK("warn_st", 1'b0, warn_status)
         end
      // Cycle limit: one timer pulse, self-clearing warning
      cycle_current_limit = 4'(1 << c);
      `WT(oc_timer_start[c] === 1'b1);
      `CHK("oc_timer", 4'(1 << c), oc_timer_start)
      `W(1);
      `CHK("oc_timer", 4'h0, oc_timer_start)
      `W(3);
      `CHK("warn_n", 1'b0, clip_thermal_warn_n)
      cycle_current_limit = 0;
      `W(8);
      `CHK("warn_n", 1'b1, clip_thermal_warn_n)
      // Overcurrent stays latched after its cause is gone
      overcurrent_fault = 4'(1 << c);
      `W(8);
      overcurrent_fault = 0;
      `W(8);
      `CHK("oc_fault", 4'(1 << c), ch_oc_fault)
      `CHK("ch_state", CH_HIZ, ch_state[c])
      `CHK("ch_state", CH_PLAY, ch_state[(c + 1) % 4])
      `CHK("oe_n", 1'b0, fault_alarm_oe_n)
      `CHK("alarm_o", 1'b0, fault_alarm_o)
      fault_clear = 1;
      `W(1);
      fault_clear = 0;
      `W(3);
      `CHK("oc_fault", 4'h0, ch_oc_fault)
      `CHK("oe_n", 1'b1, fault_alarm_oe_n)
      `CHK("ch_state", CH_PLAY, ch_state[c])
      // DC detect with its enable: latched Hi-Z until a clear
      cfg_dc_detect_en = 1;
      cfg(exp_fs[1:0], 2'h3, 1'b0, 1'b0);
      dc_detect = 4'(1 << c);
      `W(8);
      dc_detect = 0;
      `W(8);
      `CHK("dc_fault", 4'(1 << c), ch_dc_fault)
      `CHK("ch_state", CH_HIZ, ch_state[c])
      fault_clear = 1;
      `W(1);
      fault_clear = 0;
      `W(3);
      `CHK("dc_fault", 4'h0, ch_dc_fault)
      // Play to mute: status only after the ramp ends
      cmd(4'h0, 1'b0);
      `CHK("charge", 1'b0, ramp_charge)
      `WT(gain_level === GAIN_RAMP);
      `CHK("mute_st", 1'b0, mute_status)
      `WT(mute_status === 1'b1);
      `CHK("gain", GAIN_OFF, gain_level)
      // Random latched fault; a clear while it stands loses nothing
      k = $urandom_range(3);
      {thermal_shutdown, overvoltage, pump_undervoltage, undervoltage} =
         4'(1 << k);
      `W(8);
      fault_clear = 1;
      `W(1);
      {thermal_shutdown, overvoltage, pump_undervoltage, undervoltage} =
         4'h0;
      fault_clear = 0;
      `W(8);
      `CHK("gfault", 4'(1 << k), global_fault)
      `CHK("ch_state", CH_HIZ, ch_state[0])
      `CHK("oe_n", 1'b0, fault_alarm_oe_n)
      cmd(4'h0, 1'b0);
      `W(3);
      `CHK("gfault", 4'h0, global_fault)
      // Load dump: standby, bus off, alarm, then self-clears
      load_dump = 1;
      `WT(standby === 1'b1);
      `W(2);
      `CHK("i2c", 1'b0, i2c_enable)
      `CHK("oe_n", 1'b0, fault_alarm_oe_n)
      load_dump = 0;
      `WT(standby === 1'b0);
      `W(2);
      `CHK("oe_n", 1'b1, fault_alarm_oe_n)
      // Mute pin forced low during play
      cmd(4'h0, 1'b1);
      `WT(play_status === 1'b1);
      mute_pin_n = 0;
      `WT(mute_status === 1'b1);
      `CHK("gain", GAIN_OFF, gain_level)
      `W(1);
      `CHK("ch_state", CH_MUTE, ch_state[3])
      mute_pin_n = 1;
      // Deep sleep drops configuration and the bus
      cfg(2'h0, 2'h1, 1'b1, 1'b0);
      deep_sleep_n = 0;
      `W(8);
      `CHK("standby", 1'b1, standby)
      `CHK("i2c", 1'b0, i2c_enable)
      `CHK("fs_sel", 2'h1, fs_sel)
      deep_sleep_n = 1;
      give_verdict();
   end
endmodule : tb
